/* File: tmr2_defines.svh */
// register offsets, control field positions and reset values for timer two
`ifndef TMR2_DEFINES_SVH
`define TMR2_DEFINES_SVH

// ----------------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------------
`define TMR2_ADDR_CONTROL   8'hC8
`define TMR2_ADDR_RCAP_LOW  8'hCA
`define TMR2_ADDR_RCAP_HIGH 8'hCB
`define TMR2_ADDR_CNT_LOW   8'hCC
`define TMR2_ADDR_CNT_HIGH  8'hCD

// ----------------------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------------------
`define TMR2_BIT_OVF   7
`define TMR2_BIT_EXT   6
`define TMR2_BIT_RCLK  5
`define TMR2_BIT_TRANSMIT_CLOCK_SELECT  4
`define TMR2_BIT_EXEN  3
`define TMR2_BIT_RUN   2
`define TMR2_BIT_SRC   1
`define TMR2_BIT_CAP   0

// ----------------------------------------------------------------------------
// reset values and count maximum
// ----------------------------------------------------------------------------
`define TMR2_CONTROL_RESET 8'h00
`define TMR2_BYTE_RESET    8'h00
`define TMR2_COUNT_RESET   16'h0000
`define TMR2_COUNT_MAX     16'hFFFF

`endif

/* File: tmr2_pkg.sv */
// types shared by the timer two modules
package tmr2_pkg;

    // one-hot operating mode
    typedef enum logic [3:0] {
        TMR2_MODE_OFF    = 4'b0001,
        TMR2_MODE_RELOAD = 4'b0010,
        TMR2_MODE_CAPT   = 4'b0100,
        TMR2_MODE_BAUD   = 4'b1000
    } tmr2_mode_e;

endpackage

/* File: tmr2_evt_if.sv */
// event bundle from the pin edge detector to the timer core
`timescale 1ns/1ps
`default_nettype none

interface tmr2_evt_if;
    logic trig_fall;   // falling edge seen on the trigger input
    logic count_fall;  // falling edge seen on the count input

    modport src (output trig_fall, output count_fall);
    modport dst (input trig_fall, input count_fall);
endinterface

`default_nettype wire

/* File: tmr2_edge_detect.sv */
// falling edge detectors for the trigger and count inputs
`timescale 1ns/1ps
`default_nettype none

module tmr2_edge_detect (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    // pins
    input  wire logic  trigger_input_i,
    input  wire logic  count_input_i,
    // events
    tmr2_evt_if.src    evt
);

    logic trig_prev_reg;
    logic trig_prev_next;
    logic cnt_prev_reg;
    logic cnt_prev_next;

    // previous samples; reset high so a low pin at start reads as a falling edge
    always_comb begin
        trig_prev_next = trigger_input_i;
        cnt_prev_next  = count_input_i;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            trig_prev_reg <= 1'b1;
            cnt_prev_reg  <= 1'b1;
        end else begin
            trig_prev_reg <= trig_prev_next;
            cnt_prev_reg  <= cnt_prev_next;
        end
    end

    // compare previous with current sample
    assign evt.trig_fall  = trig_prev_reg & ~trigger_input_i;
    assign evt.count_fall = cnt_prev_reg & ~count_input_i;

endmodule

`default_nettype wire

/* File: tmr2_mode_decode.sv */
// operating mode decode from the control bits
`timescale 1ns/1ps
`default_nettype none

module tmr2_mode_decode (
    // control bits
    input  wire logic          run_control_i,
    input  wire logic          rclk_sel_i,
    input  wire logic          transmit_clock_select_sel_i,
    input  wire logic          capture_select_i,
    // decoded mode
    output tmr2_pkg::tmr2_mode_e mode_o
);

    // run bit overrides everything, then baud, then capture/reload
    always_comb begin
        if (!run_control_i) begin
            mode_o = tmr2_pkg::TMR2_MODE_OFF;
        end else if (rclk_sel_i | transmit_clock_select_sel_i) begin
            mode_o = tmr2_pkg::TMR2_MODE_BAUD;
        end else if (capture_select_i) begin
            mode_o = tmr2_pkg::TMR2_MODE_CAPT;
        end else begin
            mode_o = tmr2_pkg::TMR2_MODE_RELOAD;
        end
    end

endmodule

`default_nettype wire

/* File: tmr2_timer.sv */
// sixteen bit timer two with auto-reload, capture and baud clock modes
// Notes on behaviour
// - overflow flag sets on count overflow, not in baud mode; software clears
// - external flag sets on trigger-caused capture/reload; software clears it
// - receive clock select routes this overflow to receiver, else timer one
// - transmit clock select routes this overflow to transmitter, else timer one
// - trigger edges act only with trigger enable and not in baud mode
// - run bit clear stops counting whatever the other bits say
// - source select picks count input edges or core clock
// - capture select picks capture or reload; baud mode forces reload
// - baud mode whenever either serial clock select bit is set and running
// - reload mode rollover sets overflow flag and loads reload pair
// - reload mode trigger edge also reloads and sets external flag
// - capture mode trigger edge copies count into pair, sets external flag
// - capture mode counts freely, overflow sets flag with no reload
// - external flag still works in baud mode as extra interrupt
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_defines.svh"

module tmr2_timer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // special function register port
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    // pins
    input  wire logic        trigger_input_i,
    input  wire logic        count_input_i,
    // other timer overflow, for the serial clock choice
    input  wire logic        timer1_ovf_i,
    // serial port clocks and interrupt requests
    output logic             rx_baud_tick_o,
    output logic             tx_baud_tick_o,
    output logic             overflow_flag_o,
    output logic             external_event_flag_o
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] rcap_reg;
    logic [15:0] rcap_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rx_tick_reg;
    logic        rx_tick_next;
    logic        tx_tick_reg;
    logic        tx_tick_next;

    tmr2_pkg::tmr2_mode_e mode;
    tmr2_evt_if           evt ();

    logic inc;
    logic ovf;
    logic trig_act;
    logic baud_ovf;

    // ------------------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------------------
    tmr2_edge_detect u_edge (
        .clk_i           (clk_i),
        .resetn_i        (resetn_i),
        .trigger_input_i (trigger_input_i),
        .count_input_i   (count_input_i),
        .evt             (evt)
    );

    tmr2_mode_decode u_mode (
        .run_control_i    (ctrl_reg[`TMR2_BIT_RUN]),
        .rclk_sel_i       (ctrl_reg[`TMR2_BIT_RCLK]),
        .transmit_clock_select_sel_i       (ctrl_reg[`TMR2_BIT_TRANSMIT_CLOCK_SELECT]),
        .capture_select_i (ctrl_reg[`TMR2_BIT_CAP]),
        .mode_o           (mode)
    );

    // byte write to one register address
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = sfr_wr_i && (sfr_addr_i == a);
    endfunction

    // ------------------------------------------------------------------------
    // count events
    // ------------------------------------------------------------------------
    // count source and run gating
    always_comb begin
        inc = 1'b0;
        if (mode != tmr2_pkg::TMR2_MODE_OFF) begin
            inc = ctrl_reg[`TMR2_BIT_SRC] ? evt.count_fall : 1'b1;
        end
    end

    assign ovf = inc && (count_reg == `TMR2_COUNT_MAX);

    // trigger edges ignored without enable or while clocking the serial port
    assign trig_act = evt.trig_fall && ctrl_reg[`TMR2_BIT_EXEN]
                      && !ctrl_reg[`TMR2_BIT_RCLK]
                      && !ctrl_reg[`TMR2_BIT_TRANSMIT_CLOCK_SELECT];

    assign baud_ovf = ovf && (mode == tmr2_pkg::TMR2_MODE_BAUD);

    // ------------------------------------------------------------------------
    // counter, reload/capture pair and control register
    // ------------------------------------------------------------------------
    // hardware events are applied after the control and pair writes so a set wins
    // over a clear in the same cycle
    always_comb begin
        ctrl_next  = ctrl_reg;
        count_next = count_reg;
        rcap_next  = rcap_reg;

        // software writes
        if (wr_hit(`TMR2_ADDR_CONTROL)) begin
            ctrl_next = sfr_wdata_i;
        end
        if (wr_hit(`TMR2_ADDR_RCAP_LOW)) begin
            rcap_next[7:0] = sfr_wdata_i;
        end
        if (wr_hit(`TMR2_ADDR_RCAP_HIGH)) begin
            rcap_next[15:8] = sfr_wdata_i;
        end

        // counting
        if (inc) begin
            count_next = count_reg + 16'h0001;
        end

        unique case (mode)
            tmr2_pkg::TMR2_MODE_OFF: begin
                // trigger still honoured while stopped: edge path is
                // independent of the run bit
                if (trig_act) begin
                    if (ctrl_reg[`TMR2_BIT_CAP]) begin
                        rcap_next = count_reg;
                    end else begin
                        count_next = rcap_reg;
                    end
                    ctrl_next[`TMR2_BIT_EXT] = 1'b1;
                end
            end
            tmr2_pkg::TMR2_MODE_RELOAD: begin
                if (ovf || trig_act) begin
                    count_next = rcap_reg;
                end
                if (ovf) begin
                    ctrl_next[`TMR2_BIT_OVF] = 1'b1;
                end
                if (trig_act) begin
                    ctrl_next[`TMR2_BIT_EXT] = 1'b1;
                end
            end
            tmr2_pkg::TMR2_MODE_CAPT: begin
                if (ovf) begin
                    ctrl_next[`TMR2_BIT_OVF] = 1'b1;
                end
                if (trig_act) begin
                    rcap_next = count_reg;
                    ctrl_next[`TMR2_BIT_EXT] = 1'b1;
                end
            end
            tmr2_pkg::TMR2_MODE_BAUD: begin
                // forced reload, no overflow flag
                if (ovf) begin
                    count_next = rcap_reg;
                end
                // external flag may still fire from a raw trigger edge
                if (evt.trig_fall && ctrl_reg[`TMR2_BIT_EXEN]) begin
                    ctrl_next[`TMR2_BIT_EXT] = 1'b1;
                end
            end
        endcase

        // software write to count bytes takes priority over counting
        if (wr_hit(`TMR2_ADDR_CNT_LOW)) begin
            count_next[7:0] = sfr_wdata_i;
        end
        if (wr_hit(`TMR2_ADDR_CNT_HIGH)) begin
            count_next[15:8] = sfr_wdata_i;
        end
    end

    // control and data registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_reg  <= `TMR2_CONTROL_RESET;
            count_reg <= `TMR2_COUNT_RESET;
            rcap_reg  <= `TMR2_COUNT_RESET;
        end else begin
            ctrl_reg  <= ctrl_next;
            count_reg <= count_next;
            rcap_reg  <= rcap_next;
        end
    end

    // ------------------------------------------------------------------------
    // serial clock routing and read data
    // ------------------------------------------------------------------------
    // one register stage keeps every output straight off a flip-flop
    always_comb begin
        rx_tick_next = ctrl_reg[`TMR2_BIT_RCLK] ? baud_ovf
                                                : timer1_ovf_i;
        tx_tick_next = ctrl_reg[`TMR2_BIT_TRANSMIT_CLOCK_SELECT] ? baud_ovf
                                                : timer1_ovf_i;
        unique case (sfr_addr_i)
            `TMR2_ADDR_CONTROL:   rdata_next = ctrl_next;
            `TMR2_ADDR_RCAP_LOW:  rdata_next = rcap_next[7:0];
            `TMR2_ADDR_RCAP_HIGH: rdata_next = rcap_next[15:8];
            `TMR2_ADDR_CNT_LOW:   rdata_next = count_next[7:0];
            `TMR2_ADDR_CNT_HIGH:  rdata_next = count_next[15:8];
            default:              rdata_next = `TMR2_BYTE_RESET;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_tick_reg <= 1'b0;
            tx_tick_reg <= 1'b0;
            rdata_reg   <= `TMR2_BYTE_RESET;
        end else begin
            rx_tick_reg <= rx_tick_next;
            tx_tick_reg <= tx_tick_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign sfr_rdata_o           = rdata_reg;
    assign rx_baud_tick_o        = rx_tick_reg;
    assign tx_baud_tick_o        = tx_tick_reg;
    assign overflow_flag_o       = ctrl_reg[`TMR2_BIT_OVF];
    assign external_event_flag_o = ctrl_reg[`TMR2_BIT_EXT];

endmodule

`default_nettype wire

/* File: tmr2_timer_sva.sv */
// assertion checker for the timer two register port and serial clocks
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_defines.svh"

module tmr2_timer_sva (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic [7:0] sfr_rdata_o,
    // serial clocks and flags
    input  wire logic       timer1_ovf_i,
    input  wire logic       rx_baud_tick_o,
    input  wire logic       tx_baud_tick_o,
    input  wire logic       overflow_flag_o,
    input  wire logic       external_event_flag_o
);
    // ------------------------------------------------------------------
    // shadow of the mode bits
    // ------------------------------------------------------------------
    logic [5:0] ctl_reg;
    logic       wr_ctl;
    assign wr_ctl = sfr_wr_i && (sfr_addr_i == `TMR2_ADDR_CONTROL);
    // flags are hardware owned, so only the six mode bits are mirrored
    always_ff @(posedge clk_i) begin
        if (!resetn_i) ctl_reg <= 6'h00;
        else if (wr_ctl) ctl_reg <= sfr_wdata_i[5:0];
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    ovf_baud_block_a: assert property (
        $rose(overflow_flag_o) |-> !$past(ctl_reg[5] | ctl_reg[4]))
        else $error("overflow flag set in baud mode");
    ovf_needs_run_a: assert property (
        $rose(overflow_flag_o) |-> $past(ctl_reg[2]))
        else $error("overflow flag set while stopped");
    ovf_sw_clear_a: assert property (
        $fell(overflow_flag_o) |-> $past(wr_ctl && !sfr_wdata_i[7]))
        else $error("overflow flag dropped without a write");
    ext_sw_clear_a: assert property (
        $fell(external_event_flag_o) |-> $past(wr_ctl && !sfr_wdata_i[6]))
        else $error("external flag dropped without a write");
    ext_needs_en_a: assert property (
        $rose(external_event_flag_o) |-> $past(ctl_reg[3]))
        else $error("external flag set with trigger disabled");
    rx_from_t1_a: assert property (
        !$past(ctl_reg[5]) |-> rx_baud_tick_o == $past(timer1_ovf_i))
        else $error("receive clock not from other timer");
    tx_from_t1_a: assert property (
        !$past(ctl_reg[4]) |-> tx_baud_tick_o == $past(timer1_ovf_i))
        else $error("transmit clock not from other timer");
    ctl_readback_a: assert property (
        sfr_addr_i == `TMR2_ADDR_CONTROL |=> sfr_rdata_o ==
        {overflow_flag_o, external_event_flag_o, ctl_reg})
        else $error("control byte read does not match");
endmodule

`default_nettype wire

/* File: tmr2_pin_model.sv */
// pin side partner: trigger, count and other timer overflow sources
`timescale 1ns/1ps
`default_nettype none

module tmr2_pin_model (
    // clock
    input  wire logic clk_i,
    // pins
    output logic      trigger_input_o,
    output logic      count_input_o,
    output logic      timer1_ovf_o
);
    // trigger and count idle high so a release of reset is never seen as an edge; t1 idles low
    initial begin
        trigger_input_o = 1'b1;
        count_input_o   = 1'b1;
        timer1_ovf_o    = 1'b0;
    end

    // two low cycles then high, so each edge stands apart; 2 = t1 pulse
    task automatic pulse(input int pin);
        @(posedge clk_i);
        if (pin == 0) trigger_input_o <= 1'b0;
        else if (pin == 1) count_input_o <= 1'b0;
        else timer1_ovf_o <= 1'b1;
        @(posedge clk_i);
        timer1_ovf_o <= 1'b0;
        @(posedge clk_i);
        trigger_input_o <= 1'b1;
        count_input_o   <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

/* File: timer2_capture_reload_baud_tb.sv */
// self-checking testbench for timer two
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_defines.svh"

module timer2_capture_reload_baud_tb;
    localparam logic [7:0] a_ctl = `TMR2_ADDR_CONTROL;
    localparam logic [7:0] a_pl = `TMR2_ADDR_RCAP_LOW;
    localparam logic [7:0] a_ph = `TMR2_ADDR_RCAP_HIGH;
    localparam logic [7:0] a_cl = `TMR2_ADDR_CNT_LOW;
    localparam logic [7:0] a_ch = `TMR2_ADDR_CNT_HIGH;
    logic       clk_i, resetn_i, sfr_wr_i, trig, cnt, t1;
    logic       rx, tx, ovf, ext;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, n_rx, n_tx, r0, t0;
    logic [7:0] addrs [6] = '{a_ctl, a_pl, a_ph, a_cl, a_ch, 8'h00};
    int         n_errors, comparisons, cycles;

    tmr2_pin_model pins (.clk_i(clk_i), .trigger_input_o(trig),
        .count_input_o(cnt), .timer1_ovf_o(t1));
    tmr2_timer dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .trigger_input_i(trig), .count_input_i(cnt), .timer1_ovf_i(t1),
        .rx_baud_tick_o(rx), .tx_baud_tick_o(tx),
        .overflow_flag_o(ovf), .external_event_flag_o(ext));

    // clock, and tick counters plus the hang guard
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (rx === 1'b1) n_rx <= n_rx + 8'h01;
        if (tx === 1'b1) n_tx <= n_tx + 8'h01;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // register port tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i  <= a;
        sfr_wdata_i <= d;
        sfr_wr_i    <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i    <= 1'b0;
    endtask
    // pair low, pair high, count low, count high in one go
    task automatic wr4(input logic [7:0] pl, ph, cl, ch);
        wr(a_pl, pl);
        wr(a_ph, ph);
        wr(a_cl, cl);
        wr(a_ch, ch);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read data is registered: look one edge after the address lands
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        sfr_addr_i <= a;
        @(posedge clk_i);
        #1;
        chk($sformatf("reg %h", a), e, sfr_rdata_o);
    endtask
    task automatic ticks(input logic [7:0] dr, input logic [7:0] dt);
        chk("rx ticks", r0 + dr, n_rx);
        chk("tx ticks", t0 + dt, n_tx);
        r0 = n_rx;
        t0 = n_tx;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        n_rx = 8'h00;
        n_tx = 8'h00;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        wr(8'h00, 8'hFF);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        $display("test reset done");
        wr4(8'h34, 8'h12, 8'hFE, 8'hFF);
        wr(a_ctl, 8'h06);
        pins.pulse(1);
        pins.pulse(1);
        rd(a_cl, 8'h34);
        rd(a_ch, 8'h12);
        rd(a_ctl, 8'h86);
        wr(a_ctl, 8'h02);
        rd(a_ctl, 8'h02);
        pins.pulse(1);
        rd(a_cl, 8'h34);
        wr4(8'h34, 8'h12, 8'h00, 8'h00);
        wr(a_ctl, 8'h04);
        wr(a_ctl, 8'h00);
        rd(a_cl, 8'h02);
        $display("test reload done");
        wr4(8'h00, 8'h00, 8'h21, 8'h43);
        wr(a_ctl, 8'h09);
        pins.pulse(0);
        rd(a_pl, 8'h21);
        rd(a_ph, 8'h43);
        rd(a_ctl, 8'h49);
        wr4(8'h21, 8'h43, 8'hFF, 8'hFF);
        wr(a_ctl, 8'h07);
        pins.pulse(1);
        rd(a_cl, 8'h00);
        rd(a_pl, 8'h21);
        rd(a_ctl, 8'h87);
        $display("test capture done");
        wr(a_ctl, 8'h00);
        wr4(8'h34, 8'h12, 8'h00, 8'h00);
        pins.pulse(0);
        rd(a_cl, 8'h00);
        wr(a_ctl, 8'h08);
        pins.pulse(0);
        rd(a_cl, 8'h34);
        rd(a_ctl, 8'h48);
        $display("test trigger done");
        wr(a_ctl, 8'h00);
        wr4(8'hCD, 8'hAB, 8'hFF, 8'hFF);
        r0 = n_rx;
        t0 = n_tx;
        wr(a_ctl, 8'h37);
        pins.pulse(1);
        rd(a_cl, 8'hCD);
        rd(a_ch, 8'hAB);
        rd(a_ctl, 8'h37);
        ticks(8'h01, 8'h01);
        wr(a_pl, 8'h11);
        wr(a_ctl, 8'h3F);
        pins.pulse(0);
        rd(a_cl, 8'hCD);
        rd(a_pl, 8'h11);
        rd(a_ctl, 8'h7F);
        $display("test baud done");
        wr(a_ctl, 8'h00);
        r0 = n_rx;
        t0 = n_tx;
        pins.pulse(2);
        ticks(8'h01, 8'h01);
        wr(a_ctl, 8'h30);
        pins.pulse(2);
        ticks(8'h00, 8'h00);
        $display("test serial clock done");
        give_verdict();
    end
endmodule

bind tmr2_timer tmr2_timer_sva u_sva (.clk_i(clk_i), .resetn_i(resetn_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .timer1_ovf_i(timer1_ovf_i), .rx_baud_tick_o(rx_baud_tick_o),
    .tx_baud_tick_o(tx_baud_tick_o), .overflow_flag_o(overflow_flag_o),
    .external_event_flag_o(external_event_flag_o));

`default_nettype wire
